// ===== rtl/vco_divider_loop_filter_cfg.sv
// Configuration registers of the output synthesizer: VCO post-divider
// and loop-filter component selection, on an AXI4-Lite slave.
// Assumes one clock aclk; the divider counts aclk as a stand-in for VCO.
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "vco_cfg_defs.svh"

module vco_divider_loop_filter_cfg (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [`AXI_ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [`AXI_ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic div_tick,
  output logic div_powered_down,
  output logic [3:0] div_ratio,
  output vco_cfg_pkg::lf_sel_t output_synth_loop,
  output logic [7:0] tuning_value
);

  vco_cfg_pkg::cfg_state_t s;
  vco_cfg_pkg::cfg_state_t next_s;
  logic vco_wr;

  // Address decode, shared by the read and write paths
  function automatic vco_cfg_pkg::reg_sel_t reg_decode(
    input logic [`AXI_ADDR_W-1:0] a
  );
    logic [`AXI_ADDR_W-1:0] w;
    w = {a[`AXI_ADDR_W-1:2], 2'h0};
    if (w == `ADDR_OF(`IDX_VCO_DIV))
      return vco_cfg_pkg::SEL_VCO_DIV;
    else if (w == `ADDR_OF(`IDX_LOOP_FILTER))
      return vco_cfg_pkg::SEL_LOOP_FILTER;
    else if (w == `ADDR_OF(`IDX_ZERO_BYPASS))
      return vco_cfg_pkg::SEL_ZERO_BYPASS;
    else if (w == `ADDR_OF(`IDX_DIV_STATUS))
      return vco_cfg_pkg::SEL_DIV_STATUS;
    else if (w == `ADDR_OF(`IDX_TUNING))
      return vco_cfg_pkg::SEL_TUNING;
    else
      return vco_cfg_pkg::SEL_NONE;
  endfunction

  // Pole resistor in ohms
  function automatic logic [9:0] pole2_ohms(input logic [1:0] c);
    case (c)
      2'h0: return 10'd900;
      2'h1: return 10'd450;
      2'h2: return 10'd300;
      default: return 10'd225;
    endcase
  endfunction

  // Zero resistor in ohms; the table is not monotonic in the code
  function automatic logic [11:0] zero_ohms(input logic [2:0] c);
    case (c)
      3'h0: return 12'd3250;
      3'h1: return 12'd2750;
      3'h2: return 12'd2250;
      3'h3: return 12'd2100;
      3'h4: return 12'd3000;
      3'h5: return 12'd2500;
      3'h6: return 12'd2000;
      default: return 12'd1850;
    endcase
  endfunction

  // Pole capacitor in pF; codes 3 and 4 give the same value
  function automatic logic [5:0] pole1_pf(input logic [2:0] c);
    case (c)
      3'h0: return 6'd0;
      3'h1: return 6'd8;
      3'h2: return 6'd16;
      3'h3: return 6'd24;
      3'h4: return 6'd24;
      3'h5: return 6'd32;
      3'h6: return 6'd40;
      default: return 6'd48;
    endcase
  endfunction

  // Ready terms: one write and one read in flight at most
  assign awready = !s.aw_held && !s.bvalid;
  assign wready = !s.w_held && !s.bvalid;
  assign arready = !s.rvalid;
  assign bvalid = s.bvalid;
  assign bresp = s.bresp;
  assign rvalid = s.rvalid;
  assign rdata = s.rdata;
  assign rresp = s.rresp;
  assign div_tick = s.div_tick;
  assign div_powered_down = s.vco_div[`DIV_PD_BIT];
  assign div_ratio = 4'(s.vco_div[`DIV_CODE_MSB:0]) + `DIV_BASE_RATIO;
  assign output_synth_loop = s.lf_out;
  assign tuning_value = s.tuning;

  // Next state: bus slave, register file, divider and decoded filter
  always_comb begin
    vco_cfg_pkg::reg_sel_t wsel;
    vco_cfg_pkg::reg_sel_t rsel;
    logic [7:0] rval;
    logic [3:0] ratio;
    next_s = s;
    vco_wr = 1'b0;
    wsel = reg_decode(s.awaddr);
    rsel = reg_decode(araddr);
    rval = 8'h00;
    ratio = 4'(s.vco_div[`DIV_CODE_MSB:0]) + `DIV_BASE_RATIO;
    if (s.bvalid && bready)
      next_s.bvalid = 1'b0;
    if (awvalid && awready) begin
      next_s.aw_held = 1'b1;
      next_s.awaddr = awaddr;
    end
    if (wvalid && wready) begin
      next_s.w_held = 1'b1;
      next_s.wdata = wdata[7:0];
      next_s.wlane = wstrb[0];
    end
    // Commit once both halves are held; reserved bits are masked off
    if (s.aw_held && s.w_held && !s.bvalid) begin
      next_s.aw_held = 1'b0;
      next_s.w_held = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = `RESP_OKAY;
      case (wsel)
        vco_cfg_pkg::SEL_VCO_DIV: begin
          if (s.wlane) begin
            next_s.vco_div = s.wdata & `MASK_VCO_DIV;
            vco_wr = 1'b1;
          end
        end
        vco_cfg_pkg::SEL_LOOP_FILTER: begin
          if (s.wlane)
            next_s.loop_filter = s.wdata & `MASK_LOOP_FILTER;
        end
        vco_cfg_pkg::SEL_ZERO_BYPASS: begin
          if (s.wlane)
            next_s.zero_bypass = s.wdata & `MASK_ZERO_BYPASS;
        end
        vco_cfg_pkg::SEL_TUNING: begin
          if (s.wlane)
            next_s.tuning = s.wdata & `MASK_TUNING;
        end
        vco_cfg_pkg::SEL_DIV_STATUS: begin
          next_s.bresp = `RESP_OKAY; // Read-only, write dropped
        end
        default: next_s.bresp = `RESP_SLVERR;
      endcase
    end
    // Read path answers one cycle after the address is taken
    if (s.rvalid && rready)
      next_s.rvalid = 1'b0;
    if (arvalid && arready) begin
      case (rsel)
        vco_cfg_pkg::SEL_VCO_DIV: rval = s.vco_div;
        vco_cfg_pkg::SEL_LOOP_FILTER: rval = s.loop_filter;
        vco_cfg_pkg::SEL_ZERO_BYPASS: rval = s.zero_bypass;
        vco_cfg_pkg::SEL_DIV_STATUS:
          rval = {!s.vco_div[`DIV_PD_BIT], 3'h0, s.div_count};
        vco_cfg_pkg::SEL_TUNING: rval = s.tuning;
        default: rval = 8'h00;
      endcase
      next_s.rvalid = 1'b1;
      next_s.rdata = {24'h000000, rval};
      next_s.rresp = (rsel == vco_cfg_pkg::SEL_NONE) ? `RESP_SLVERR :
                     `RESP_OKAY;
    end
    // Shared divider; >= lets a smaller ratio take effect at once
    if (s.vco_div[`DIV_PD_BIT]) begin
      next_s.div_count = 4'h0;
      next_s.div_tick = 1'b0;
    end else if (s.div_count >= ratio - 4'h1) begin
      next_s.div_count = 4'h0;
      next_s.div_tick = 1'b1;
    end else begin
      next_s.div_count = s.div_count + 4'h1;
      next_s.div_tick = 1'b0;
    end
    // Decoded loop-filter values, with the zero resistor bypass
    next_s.lf_out.second_pole_resistance =
      pole2_ohms(s.loop_filter[`POLE2_MSB:`POLE2_LSB]);
    next_s.lf_out.first_pole_capacitance =
      pole1_pf(s.loop_filter[`POLE1_MSB:0]);
    next_s.lf_out.zero_bypassed = s.zero_bypass[`BYPASS_BIT];
    next_s.lf_out.zero_resistance = s.zero_bypass[`BYPASS_BIT] ? 12'd0 :
      zero_ohms(s.loop_filter[`ZERO_MSB:`ZERO_LSB]);
  end

  // State register; decoded outputs reset to the code-zero values
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
      s.vco_div <= `RST_VCO_DIV;
      s.loop_filter <= `RST_LOOP_FILTER;
      s.zero_bypass <= `RST_ZERO_BYPASS;
      s.tuning <= `RST_TUNING;
      s.lf_out.second_pole_resistance <= 10'd900;
      s.lf_out.zero_resistance <= 12'd3250;
    end else begin
      s <= next_s;
    end
  end

  // Cycles since the last tick, only for checking the period
  logic [3:0] gap;
  logic gap_valid;
  always_ff @(posedge aclk) begin
    if (!aresetn || s.vco_div[`DIV_PD_BIT] || vco_wr) begin
      gap <= 4'h0;
      gap_valid <= 1'b0;
    end else if (s.div_tick) begin
      gap <= 4'h0;
      gap_valid <= 1'b1;
    end else begin
      gap <= gap + 4'h1;
    end
  end

  a_pd_no_tick: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(s.vco_div[`DIV_PD_BIT]) && s.vco_div[`DIV_PD_BIT] |-> !div_tick)
    else $error("divider ticks while powered down");
  a_div_min_gap: assert property (@(posedge aclk) disable iff (!aresetn)
    div_tick |=> !div_tick [*3])
    else $error("divider period shorter than four");
  a_div_period: assert property (@(posedge aclk) disable iff (!aresetn)
    div_tick && gap_valid |-> gap == div_ratio - 4'h1)
    else $error("divider period differs from code plus four");
  a_pole2_map: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(s.loop_filter[7:6]) == 2'h2 |->
    output_synth_loop.second_pole_resistance == 10'd300)
    else $error("pole resistor value wrong");
  a_zero_map: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(s.loop_filter[5:3]) == 3'h4 && !$past(s.zero_bypass[0]) |->
    output_synth_loop.zero_resistance == 12'd3000)
    else $error("zero resistor value wrong");
  a_cap_equal: assert property (@(posedge aclk) disable iff (!aresetn)
    ($past(s.loop_filter[2:0]) == 3'h3 || $past(s.loop_filter[2:0]) == 3'h4)
    |-> output_synth_loop.first_pole_capacitance == 6'd24)
    else $error("pole capacitor codes 3 and 4 differ");
  a_bypass_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(s.zero_bypass[0]) |-> output_synth_loop.zero_resistance == 12'd0
    && output_synth_loop.zero_bypassed)
    else $error("bypass did not short zero resistor");
  a_tuning_reset: assert property (@(posedge aclk)
    $past(!aresetn) |-> tuning_value == 8'h00)
    else $error("tuning register not zero after reset");
  a_rsvd_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    s.vco_div[7:4] == 4'h0 && s.zero_bypass[7:1] == 7'h00 &&
    (!rvalid || rdata[31:8] == 24'h000000))
    else $error("reserved bits not zero");

endmodule

// ===== rtl/vco_cfg_defs.svh
// Offsets, field positions, reset values and masks of the VCO divider
// and loop-filter configuration block. Assumes an AXI4-Lite slave decode.
`ifndef VCO_CFG_DEFS_SVH
`define VCO_CFG_DEFS_SVH

`define AXI_ADDR_W 12
// Register indices; byte address is four times the index
`define IDX_VCO_DIV 12'h0F4
`define IDX_LOOP_FILTER 12'h0F5
`define IDX_ZERO_BYPASS 12'h0F6
`define IDX_DIV_STATUS 12'h0F7
`define IDX_TUNING 12'h190
`define ADDR_OF(idx) ((idx) << 2)

// Writable bit masks; everything else is reserved
`define MASK_VCO_DIV 8'h0F
`define MASK_LOOP_FILTER 8'hFF
`define MASK_ZERO_BYPASS 8'h01
`define MASK_TUNING 8'hFF

// Reset values and the recommended tuning value
`define RST_VCO_DIV 8'h00
`define RST_LOOP_FILTER 8'h00
`define RST_ZERO_BYPASS 8'h00
`define RST_TUNING 8'h00
`define TUNING_RECOMMENDED 8'h20

// Field positions and the divider base ratio
`define DIV_PD_BIT 3
`define DIV_CODE_MSB 2
`define DIV_BASE_RATIO 4'h4
`define POLE2_MSB 7
`define POLE2_LSB 6
`define ZERO_MSB 5
`define ZERO_LSB 3
`define POLE1_MSB 2
`define BYPASS_BIT 0

// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ===== rtl/vco_cfg_pkg.sv
// Types shared by the configuration block: selected loop-filter values
// and the whole state of the block. Needs vco_cfg_defs.svh.
`include "vco_cfg_defs.svh"

package vco_cfg_pkg;

  typedef enum logic [2:0] {
    SEL_NONE = 3'h0,
    SEL_VCO_DIV = 3'h1,
    SEL_LOOP_FILTER = 3'h2,
    SEL_ZERO_BYPASS = 3'h3,
    SEL_DIV_STATUS = 3'h4,
    SEL_TUNING = 3'h5
  } reg_sel_t;

  typedef struct packed {
    logic [9:0] second_pole_resistance;
    logic [11:0] zero_resistance;
    logic [5:0] first_pole_capacitance;
    logic zero_bypassed;
  } lf_sel_t;

  typedef struct packed {
    logic [7:0] vco_div;
    logic [7:0] loop_filter;
    logic [7:0] zero_bypass;
    logic [7:0] tuning;
    logic aw_held;
    logic [`AXI_ADDR_W-1:0] awaddr;
    logic w_held;
    logic [7:0] wdata;
    logic wlane;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [3:0] div_count;
    logic div_tick;
    lf_sel_t lf_out;
  } cfg_state_t;

endpackage

// ===== testbench/vco_divider_loop_filter_cfg_bench.sv
// Self-checking bench of the VCO divider and loop-filter block.
// Drives the AXI4-Lite slave ports directly; model kept in arrays.
`timescale 1ns/100ps
`include "vco_cfg_defs.svh"

module vco_divider_loop_filter_cfg_bench;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, div_tick;
  logic div_powered_down, b;
  logic [`AXI_ADDR_W-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata, seed;
  logic [3:0] wstrb, div_ratio;
  logic [1:0] bresp, rresp;
  logic [7:0] tuning_value, v;
  logic [7:0] mdl[4];
  vco_cfg_pkg::lf_sel_t output_synth_loop;
  int err_count, checks, n;
  logic [11:0] ad[4] = '{`ADDR_OF(`IDX_VCO_DIV), `ADDR_OF(`IDX_LOOP_FILTER),
    `ADDR_OF(`IDX_ZERO_BYPASS), `ADDR_OF(`IDX_TUNING)};
  logic [7:0] mk[4] = '{`MASK_VCO_DIV, `MASK_LOOP_FILTER,
    `MASK_ZERO_BYPASS, `MASK_TUNING};
  int p2[4] = '{900, 450, 300, 225};
  int zr[8] = '{3250, 2750, 2250, 2100, 3000, 2500, 2000, 1850};
  int cp[8] = '{0, 8, 16, 24, 24, 32, 40, 48};

  vco_divider_loop_filter_cfg vco_divider_loop_filter_cfg_inst (
    .aclk, .aresetn, .awaddr, .awprot(3'h0), .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
    .araddr, .arprot(3'h0), .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .div_tick, .div_powered_down, .div_ratio,
    .output_synth_loop, .tuning_value);

  // Free-running 20 MHz clock
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  // Expected selection word; bypass forces the zero resistance to 0
  function automatic logic [31:0] lf_exp(input logic [7:0] f,
                                         input logic y);
    return {3'h0, 10'(p2[f[7:6]]), y ? 12'h000 : 12'(zr[f[5:3]]),
      6'(cp[f[2:0]]), y};
  endfunction

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    chk_val({30'h0, got}, {30'h0, exp});
  endtask

  // Each half released at its own handshake; bready and rready stay high,
  // so back-to-back calls never drive a ready line twice in one step
  task automatic wr(input logic [11:0] a, input logic [7:0] d,
                    input logic s, input logic [1:0] er);
    awaddr <= a;
    wdata <= {xs(seed[31:0]) & 32'hFFFFFF00} | {24'h0, d};
    wstrb <= {3'h7, s};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    chk_resp(bresp, er);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] ed,
                    input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    chk_val(rdata, ed);
    chk_resp(rresp, er);
  endtask

  // Model update keeps only the writable bits
  task automatic mwr(input int k, input logic [7:0] d);
    wr(ad[k], d, 1'b1, `RESP_OKAY);
    mdl[k] = d & mk[k];
  endtask

  task automatic mrd(input int k);
    rd(ad[k], {24'h0, mdl[k]}, `RESP_OKAY);
  endtask

  task automatic wait_tick;
    do @(posedge aclk); while (div_tick !== 1'b1);
  endtask

  task automatic tally_and_finish;
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, aresetn} = 6'h00;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = '0;
    seed = 32'hFBD87CD3;
    mdl = '{default: 8'h00};
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    for (int k = 0; k < 4; k++) mrd(k);
    chk_val({3'h0, output_synth_loop}, lf_exp(8'h00, 1'b0));
    chk_val({28'h0, div_ratio}, 32'h4);
    // Random data; upper bits must vanish
    for (int k = 0; k < 4; k++) begin
      seed = xs(seed);
      mwr(k, seed[7:0]);
      mrd(k);
    end
    chk_val({24'h0, tuning_value}, {24'h0, mdl[3]});
    // Lane off, unmapped place and status writes change nothing
    wr(ad[3], ~mdl[3], 1'b0, `RESP_OKAY);
    mrd(3);
    wr(12'h004, 8'h55, 1'b1, `RESP_SLVERR);
    rd(12'h004, 32'h0, `RESP_SLVERR);
    wr(`ADDR_OF(`IDX_DIV_STATUS), 8'hFF, 1'b1, `RESP_OKAY);
    mrd(0);
    // Every ratio code; first two intervals after a change are skipped
    for (int i = 0; i < 8; i++) begin
      mwr(0, 8'(i));
      chk_val({28'h0, div_ratio}, 32'(i + 4));
      wait_tick;
      wait_tick;
      n = 0;
      do begin
        @(posedge aclk);
        n++;
      end while (div_tick !== 1'b1);
      chk_val(32'(n), 32'(i + 4));
    end
    // Power-down silences the divider, status shows it stopped
    mwr(0, 8'hFF);
    n = 0;
    repeat (40) begin
      @(posedge aclk);
      if (div_tick === 1'b1) n++;
    end
    chk_val(32'(n), 32'h0);
    chk_val({31'h0, div_powered_down}, 32'h1);
    rd(`ADDR_OF(`IDX_DIV_STATUS), 32'h0, `RESP_OKAY);
    mwr(0, 8'h07);
    wait_tick;
    chk_val({31'h0, div_powered_down}, 32'h0);
    // All component codes, then bypass with a random selection
    for (int i = 0; i < 9; i++) begin
      seed = xs(seed);
      v = (i < 8) ? {i[1:0], i[2:0], i[2:0]} : seed[7:0];
      b = (i == 8);
      mwr(1, v);
      mwr(2, {7'h7F, b});
      repeat (2) @(posedge aclk);
      chk_val({3'h0, output_synth_loop}, lf_exp(v, b));
    end
    mwr(3, `TUNING_RECOMMENDED);
    chk_val({24'h0, tuning_value}, 32'h20);
    // Second reset in mid-run clears the tuning register again
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    mdl = '{default: 8'h00};
    mrd(3);
    tally_and_finish;
  end

  // Whole run needs a few hundred cycles; this cuts a hang short
  initial begin
    repeat (20000) @(posedge aclk);
    err_count++;
    tally_and_finish;
  end
endmodule
